// [rpt_pkg.sv]
/*
 * Package and control-field decoder for the registration packet tail.
 * Assumes one MAC clock; the package is compiled before every other file.
 */
`timescale 1ns/1ps

package rpt_pkg;

    // ==================================================================
    // Message variants of the registration control packet
    typedef enum logic [2:0] {
        RPT_MSG_REQ,
        RPT_MSG_RSP,
        RPT_MSG_ACK,
        RPT_MSG_REJ,
        RPT_MSG_UNR_S,
        RPT_MSG_UNR_B
    } rpt_msg_e;

    // ==================================================================
    // Field widths and byte counts
    localparam int RPT_HWID_W = 48;
    localparam int RPT_NONCE_W = 32;
    localparam int RPT_KEY_W = 192;
    localparam int RPT_LNID_W = 14;
    localparam int RPT_SID_W = 8;
    localparam logic [5:0] RPT_HWID_BYTES = 6'h06;
    localparam logic [5:0] RPT_CTRL_IDX = 6'h06;
    localparam logic [5:0] RPT_NONCE_BYTES = 6'h04;
    localparam logic [5:0] RPT_KEY_BYTES = 6'h18;
    localparam logic [5:0] RPT_BASE_LEN = 6'h07;

    // Control byte: forced_modulation[7:6], seg_size_limit[5:3], reserved[2:0]
    localparam int RPT_FM_POS = 6;
    localparam int RPT_SEG_POS = 3;
    localparam logic [2:0] RPT_RSVD_VAL = 3'h0;

    // Local identifier meaning "none assigned"
    localparam logic [13:0] RPT_LNID_NONE = 14'h3fff;

    // Forced modulation codes
    localparam logic [1:0] RPT_FM_AUTO = 2'h0;
    localparam logic [1:0] RPT_FM_DBPSK_CODED = 2'h1;
    localparam logic [1:0] RPT_FM_DQPSK_ROBUST = 2'h2;
    localparam logic [1:0] RPT_FM_DBPSK_ROBUST = 2'h3;

    // Segment size limits in bytes for codes 1 to 7
    localparam logic [7:0] RPT_SEG_1 = 8'h10;
    localparam logic [7:0] RPT_SEG_2 = 8'h20;
    localparam logic [7:0] RPT_SEG_3 = 8'h30;
    localparam logic [7:0] RPT_SEG_4 = 8'h40;
    localparam logic [7:0] RPT_SEG_5 = 8'h80;
    localparam logic [7:0] RPT_SEG_6 = 8'hc0;
    localparam logic [7:0] RPT_SEG_7 = 8'hff;

    // Reset values of the applied configuration
    localparam logic [1:0] RPT_FM_RST = 2'h0;
    localparam logic [2:0] RPT_SEG_RST = 3'h0;

    // ==================================================================
    // Nonce counter present in request, response and reject when secured
    function automatic logic has_nonce(input rpt_msg_e msg, input logic secure);
        has_nonce = secure && (msg == RPT_MSG_REQ || msg == RPT_MSG_RSP || msg == RPT_MSG_REJ);
    endfunction

    // Wrapped keys present only in a secured response
    function automatic logic has_keys(input rpt_msg_e msg, input logic secure);
        has_keys = secure && (msg == RPT_MSG_RSP);
    endfunction

    // Tail length in bytes for one message variant
    function automatic logic [5:0] tail_len(input rpt_msg_e msg, input logic secure);
        logic [5:0] len;
        len = RPT_BASE_LEN;
        if (has_nonce(msg, secure))
            len = len + RPT_NONCE_BYTES;
        if (has_keys(msg, secure))
            len = len + RPT_KEY_BYTES + RPT_KEY_BYTES;
        tail_len = len;
    endfunction

endpackage

// ======================================================================
// Decoder of the applied modulation and segment-size codes
module rpt_ctrl_decode (
    input wire logic [1:0] i_fm_code,
    input wire logic [2:0] i_seg_code,
    output logic o_mod_auto,
    output logic o_sel_dbpsk_coded,
    output logic o_sel_dqpsk_robust,
    output logic o_sel_dbpsk_robust,
    output logic o_seg_limit_en,
    output logic [7:0] o_seg_limit_bytes
);

    // Modulation code to one-hot scheme select
    assign o_mod_auto = (i_fm_code == rpt_pkg::RPT_FM_AUTO); // R02
    assign o_sel_dbpsk_coded = (i_fm_code == rpt_pkg::RPT_FM_DBPSK_CODED); // R02
    assign o_sel_dqpsk_robust = (i_fm_code == rpt_pkg::RPT_FM_DQPSK_ROBUST); // R02
    assign o_sel_dbpsk_robust = (i_fm_code == rpt_pkg::RPT_FM_DBPSK_ROBUST); // R02

    // Segment code to byte limit; code 0 means no limit
    always_comb
    begin
        o_seg_limit_en = (i_seg_code != 3'h0); // R06
        unique case (i_seg_code) // R05
            3'h1: o_seg_limit_bytes = rpt_pkg::RPT_SEG_1;
            3'h2: o_seg_limit_bytes = rpt_pkg::RPT_SEG_2;
            3'h3: o_seg_limit_bytes = rpt_pkg::RPT_SEG_3;
            3'h4: o_seg_limit_bytes = rpt_pkg::RPT_SEG_4;
            3'h5: o_seg_limit_bytes = rpt_pkg::RPT_SEG_5;
            3'h6: o_seg_limit_bytes = rpt_pkg::RPT_SEG_6;
            3'h7: o_seg_limit_bytes = rpt_pkg::RPT_SEG_7;
            3'h0: o_seg_limit_bytes = 8'h00;
        endcase
    end

endmodule

// [rpt_tail.sv]
/*
 * Registration packet tail framer and parser for a service node MAC.
 * Builds the uplink tail as a byte stream and parses the downlink tail,
 * applying the modulation and segment-size settings of a response.
 * Assumes byte streams and header fields come from logic on the same clock.
 */
// Contract
// R01 - Tail carries the 48-bit hardware identifier of the registering node.
// R02 - Modulation code: 0 automatic, 1 dbpsk_coded, 2 dqpsk_robust, 3 dbpsk_robust.
// R03 - Nonzero received modulation forces that scheme only, no automatic management.
// R04 - Modulation and segment fields used only in responses, zero elsewhere.
// R05 - Segment codes 1 to 7 mean 16,32,48,64,128,192,255 bytes.
// R06 - Segment code 0 means no limit; otherwise never exceed decoded size.
// R07 - Three reserved bits after segment field are sent as zero.
// R08 - 32-bit nonce counter field for registration authentication.
// R09 - 192-bit wrapped subnetwork key field, source of the working key.
// R10 - 192-bit wrapped authentication key field.
// R11 - Header switch identifier names the switch used for registration.
// R12 - Header local identifier carries the identifier being assigned.
// R13 - Uplink request aggregation flag reports only own capability.
// R14 - Base sets downlink aggregation flag only if whole path supports it.
// R15 - Wrapped keys present only in secured responses, else omitted.
// R16 - Nonce present only in secured request, response, reject.
// R17 - Response goes downlink with identifier below 0x3fff and assigns it.
// R18 - Fields go MSB first: identifier, modulation, segment, reserved, nonce, keys.
`timescale 1ns/1ps

module rpt_tail (
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Transmit command
    input wire logic i_tx_start,
    input wire rpt_pkg::rpt_msg_e i_tx_msg,
    input wire logic i_tx_secure,
    input wire logic [47:0] i_node_hw_identifier,
    input wire logic [31:0] i_tx_nonce,
    input wire logic i_aggr_capable,
    output logic o_tx_busy,
    // Transmit byte stream and header fields
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    input wire logic i_tx_ready,
    output logic o_tx_aggregation_capable_flag,
    output logic [13:0] o_tx_local_node_id,
    // Receive header fields, taken with i_rx_start
    input wire logic i_rx_start,
    input wire rpt_pkg::rpt_msg_e i_rx_msg,
    input wire logic i_rx_secure,
    input wire logic [7:0] i_rx_switch_identifier,
    input wire logic [13:0] i_rx_local_node_id,
    input wire logic i_rx_aggregation_capable_flag,
    // Receive byte stream
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    // Parsed results
    output logic o_rx_done,
    output logic o_rx_field_err,
    output logic [47:0] o_rx_hw_identifier,
    output logic [31:0] o_reg_nonce_counter,
    output logic [191:0] o_wrapped_subnet_key,
    output logic [191:0] o_wrapped_auth_key,
    output logic o_keys_valid,
    output logic [13:0] o_assigned_local_node_id,
    output logic [7:0] o_switch_identifier,
    output logic o_registered,
    output logic o_aggr_enabled,
    // Applied link settings
    output logic o_mod_auto,
    output logic o_sel_dbpsk_coded,
    output logic o_sel_dqpsk_robust,
    output logic o_sel_dbpsk_robust,
    output logic o_seg_limit_en,
    output logic [7:0] o_seg_limit_bytes
);

    typedef enum logic {RPT_IDLE, RPT_RUN} rpt_state_e;

    // ==================================================================
    // Transmit side
    localparam int TX_SR_W = 88;

    rpt_state_e tx_state_q;
    logic [5:0] tx_idx_q;
    logic [5:0] tx_len_q;
    logic [TX_SR_W-1:0] tx_sr_q;
    logic tx_aggr_q;
    logic [13:0] tx_lnid_q;
    logic tx_take;
    logic tx_step;
    logic [7:0] tx_ctrl;

    assign tx_take = (tx_state_q == RPT_IDLE) && i_tx_start;
    assign tx_step = (tx_state_q == RPT_RUN) && i_tx_ready;
    // Uplink control byte: no modulation, no segment limit, reserved zero
    assign tx_ctrl = {rpt_pkg::RPT_FM_AUTO, 3'h0, rpt_pkg::RPT_RSVD_VAL}; // R04 R07

    // Transmit sequencer
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            tx_state_q <= RPT_IDLE;
            tx_idx_q <= 6'h00;
            tx_len_q <= rpt_pkg::RPT_BASE_LEN;
        end
        else if (tx_take)
        begin
            tx_state_q <= RPT_RUN;
            tx_idx_q <= 6'h00;
            tx_len_q <= rpt_pkg::tail_len(i_tx_msg, i_tx_secure); // R15 R16
        end
        else if (tx_step)
        begin
            tx_idx_q <= tx_idx_q + 6'h01;
            if (o_tx_last)
                tx_state_q <= RPT_IDLE;
        end
    end

    // Tail shift register, most significant byte leaves first
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            tx_sr_q <= '0;
        else if (tx_take)
            tx_sr_q <= {i_node_hw_identifier, tx_ctrl, i_tx_nonce}; // R01 R08 R18
        else if (tx_step)
            tx_sr_q <= {tx_sr_q[TX_SR_W-9:0], 8'h00}; // R18
    end

    // Header fields sent with the tail
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            tx_aggr_q <= 1'b0;
            tx_lnid_q <= rpt_pkg::RPT_LNID_NONE;
        end
        else if (tx_take)
        begin
            tx_aggr_q <= i_aggr_capable; // R13
            if (i_tx_msg == rpt_pkg::RPT_MSG_REQ)
                tx_lnid_q <= rpt_pkg::RPT_LNID_NONE;
            else
                tx_lnid_q <= o_assigned_local_node_id; // R12
        end
    end

    assign o_tx_busy = (tx_state_q == RPT_RUN);
    assign o_tx_valid = (tx_state_q == RPT_RUN);
    assign o_tx_data = tx_sr_q[TX_SR_W-1:TX_SR_W-8];
    assign o_tx_last = (tx_state_q == RPT_RUN) && (tx_idx_q == tx_len_q - 6'h01);
    assign o_tx_aggregation_capable_flag = tx_aggr_q;
    assign o_tx_local_node_id = tx_lnid_q;

    // ==================================================================
    // Receive side
    rpt_state_e rx_state_q;
    logic [5:0] rx_idx_q;
    logic [5:0] rx_len_q;
    rpt_pkg::rpt_msg_e rx_msg_q;
    logic rx_secure_q;
    logic [7:0] rx_sid_q;
    logic [13:0] rx_lnid_q;
    logic rx_aggr_q;
    logic [47:0] rx_id_q;
    logic [7:0] rx_ctrl_q;
    logic [31:0] rx_nonce_q;
    logic [191:0] rx_swk_q;
    logic [191:0] rx_wk_q;
    logic rx_byte;
    logic rx_end;
    logic [5:0] rx_swk_lo;
    logic [5:0] rx_wk_lo;
    logic [7:0] rx_ctrl_w;
    logic [31:0] rx_nonce_w;
    logic [191:0] rx_wk_w;
    logic rx_is_rsp;
    logic rx_err;

    assign rx_byte = (rx_state_q == RPT_RUN) && i_rx_valid;
    assign rx_end = rx_byte && (rx_idx_q == rx_len_q - 6'h01);
    assign rx_swk_lo = rpt_pkg::RPT_BASE_LEN + rpt_pkg::RPT_NONCE_BYTES;
    assign rx_wk_lo = rx_swk_lo + rpt_pkg::RPT_KEY_BYTES;

    // Receive sequencer; header fields latched at packet start
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            rx_state_q <= RPT_IDLE;
            rx_idx_q <= 6'h00;
            rx_len_q <= rpt_pkg::RPT_BASE_LEN;
            rx_msg_q <= rpt_pkg::RPT_MSG_REQ;
            rx_secure_q <= 1'b0;
            rx_sid_q <= 8'h00;
            rx_lnid_q <= rpt_pkg::RPT_LNID_NONE;
            rx_aggr_q <= 1'b0;
        end
        else if (i_rx_start)
        begin
            rx_state_q <= RPT_RUN;
            rx_idx_q <= 6'h00;
            rx_len_q <= rpt_pkg::tail_len(i_rx_msg, i_rx_secure); // R15 R16
            rx_msg_q <= i_rx_msg;
            rx_secure_q <= i_rx_secure;
            rx_sid_q <= i_rx_switch_identifier;
            rx_lnid_q <= i_rx_local_node_id;
            rx_aggr_q <= i_rx_aggregation_capable_flag;
        end
        else if (rx_byte)
        begin
            rx_idx_q <= rx_idx_q + 6'h01;
            if (rx_end)
                rx_state_q <= RPT_IDLE;
        end
    end

    // Field capture by byte position, most significant byte first
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            rx_id_q <= '0;
            rx_ctrl_q <= 8'h00;
            rx_nonce_q <= '0;
            rx_swk_q <= '0;
            rx_wk_q <= '0;
        end
        else if (rx_byte)
        begin
            if (rx_idx_q < rpt_pkg::RPT_HWID_BYTES)
                rx_id_q <= {rx_id_q[39:0], i_rx_data}; // R01 R18
            else if (rx_idx_q == rpt_pkg::RPT_CTRL_IDX)
                rx_ctrl_q <= i_rx_data;
            else if (rx_idx_q < rx_swk_lo)
                rx_nonce_q <= {rx_nonce_q[23:0], i_rx_data}; // R08
            else if (rx_idx_q < rx_wk_lo)
                rx_swk_q <= {rx_swk_q[183:0], i_rx_data}; // R09
            else
                rx_wk_q <= {rx_wk_q[183:0], i_rx_data}; // R10
        end
    end

    // Values including the byte taken on the final cycle
    assign rx_ctrl_w = (rx_idx_q == rpt_pkg::RPT_CTRL_IDX) ? i_rx_data : rx_ctrl_q;
    assign rx_nonce_w = {rx_nonce_q[23:0], i_rx_data};
    assign rx_wk_w = {rx_wk_q[183:0], i_rx_data};
    assign rx_is_rsp = (rx_msg_q == rpt_pkg::RPT_MSG_RSP);
    // Nonzero settings outside a response, or reserved bits set
    assign rx_err = (!rx_is_rsp && (rx_ctrl_w[7:3] != 5'h00)) // R04
        || (rx_ctrl_w[2:0] != rpt_pkg::RPT_RSVD_VAL); // R07

    // Results committed when the last tail byte arrives
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_rx_done <= 1'b0;
            o_rx_field_err <= 1'b0;
            o_rx_hw_identifier <= '0;
            o_reg_nonce_counter <= '0;
            o_wrapped_subnet_key <= '0;
            o_wrapped_auth_key <= '0;
            o_keys_valid <= 1'b0;
        end
        else
        begin
            o_rx_done <= rx_end;
            if (rx_end)
            begin
                o_rx_field_err <= rx_err;
                o_rx_hw_identifier <= (rx_len_q == rpt_pkg::RPT_BASE_LEN) ?
                    {rx_id_q[47:0]} : rx_id_q;
                if (rpt_pkg::has_nonce(rx_msg_q, rx_secure_q))
                    o_reg_nonce_counter <= (rx_len_q == rpt_pkg::RPT_BASE_LEN
                        + rpt_pkg::RPT_NONCE_BYTES) ? rx_nonce_w : rx_nonce_q; // R16
                if (rpt_pkg::has_keys(rx_msg_q, rx_secure_q))
                begin
                    o_wrapped_subnet_key <= rx_swk_q; // R09 R15
                    o_wrapped_auth_key <= rx_wk_w; // R10 R15
                    o_keys_valid <= 1'b1;
                end
            end
        end
    end

    // Registration state from an accepted response
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_assigned_local_node_id <= rpt_pkg::RPT_LNID_NONE;
            o_switch_identifier <= 8'h00;
            o_registered <= 1'b0;
            o_aggr_enabled <= 1'b0;
        end
        else if (rx_end && rx_is_rsp && (rx_lnid_q < rpt_pkg::RPT_LNID_NONE)) // R17
        begin
            o_assigned_local_node_id <= rx_lnid_q; // R12 R17
            o_switch_identifier <= rx_sid_q; // R11
            o_registered <= 1'b1;
            o_aggr_enabled <= rx_aggr_q; // R14
        end
    end

    // ==================================================================
    // Applied modulation and segment settings
    logic [1:0] fm_q;
    logic [2:0] seg_q;

    // Only a response may change the settings
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            fm_q <= rpt_pkg::RPT_FM_RST;
            seg_q <= rpt_pkg::RPT_SEG_RST;
        end
        else if (rx_end && rx_is_rsp && !rx_err) // R04
        begin
            fm_q <= rx_ctrl_w[rpt_pkg::RPT_FM_POS +: 2]; // R03
            seg_q <= rx_ctrl_w[rpt_pkg::RPT_SEG_POS +: 3]; // R06
        end
    end

    // Scheme select and segment limit for the transmit path
    rpt_ctrl_decode u_decode (
        .i_fm_code(fm_q),
        .i_seg_code(seg_q),
        .o_mod_auto(o_mod_auto),
        .o_sel_dbpsk_coded(o_sel_dbpsk_coded),
        .o_sel_dqpsk_robust(o_sel_dqpsk_robust),
        .o_sel_dbpsk_robust(o_sel_dbpsk_robust),
        .o_seg_limit_en(o_seg_limit_en),
        .o_seg_limit_bytes(o_seg_limit_bytes)
    );

endmodule

// [rpt_tail_props.sv]
/*
 * Checker for the registration packet tail block, bound to its top module.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

// ==================================================================
// Port-level relations of the tail framer and parser
module rpt_tail_props (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_start,
    input wire rpt_pkg::rpt_msg_e i_tx_msg,
    input wire logic i_aggr_capable,
    input wire logic i_tx_ready,
    input wire logic o_tx_busy,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic o_tx_last,
    input wire logic o_tx_aggregation_capable_flag,
    input wire logic [13:0] o_tx_local_node_id,
    input wire logic o_rx_done,
    input wire logic o_keys_valid,
    input wire logic o_mod_auto,
    input wire logic o_sel_dbpsk_coded,
    input wire logic o_sel_dqpsk_robust,
    input wire logic o_sel_dbpsk_robust,
    input wire logic o_seg_limit_en,
    input wire logic [7:0] o_seg_limit_bytes
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    tx_take_a: assert property (i_tx_start && !o_tx_busy |=> o_tx_valid && o_tx_busy)
        else $error("start not answered by a byte");
    byte_hold_a: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("byte changed while stalled");
    last_end_a: assert property (o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid)
        else $error("stream ran past last byte");
    req_lnid_a: assert property (
        i_tx_start && !o_tx_busy && i_tx_msg == rpt_pkg::RPT_MSG_REQ
        |=> o_tx_local_node_id == 14'h3fff) else $error("request id not none");
    own_aggr_a: assert property (i_tx_start && !o_tx_busy
        |=> o_tx_aggregation_capable_flag == $past(i_aggr_capable))
        else $error("tx aggregation flag wrong");
    mod_onehot_a: assert property ($onehot({o_mod_auto, o_sel_dbpsk_coded,
        o_sel_dqpsk_robust, o_sel_dbpsk_robust})) else $error("modulation not one-hot");
    seg_table_a: assert property (o_seg_limit_en |-> o_seg_limit_bytes inside
        {8'h10, 8'h20, 8'h30, 8'h40, 8'h80, 8'hc0, 8'hff})
        else $error("segment size off table");
    apply_done_a: assert property (!o_rx_done |-> $stable(o_seg_limit_bytes)
        && $stable(o_mod_auto) && $stable(o_seg_limit_en))
        else $error("settings moved without done");
    done_pulse_a: assert property (o_rx_done |=> !o_rx_done)
        else $error("done longer than one cycle");
    keys_done_a: assert property ($rose(o_keys_valid) |-> o_rx_done)
        else $error("keys valid without done");
endmodule

// [rpt_peer.sv]
/*
 * Behavioural peer node: accepts the uplink byte stream, sends downlink bytes.
 * Assumes the bench calls push and reads got; same clock as the block.
 */
`timescale 1ns/1ps

// ==================================================================
// Peer node model
module rpt_peer (
    input wire logic i_clk,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data
);
    logic slow = 1'b0;
    logic [7:0] got[$];

    initial
    begin
        o_tx_ready = 1'b1;
        o_rx_valid = 1'b0;
        o_rx_data = 8'h5a;
    end

    // Collect accepted uplink bytes in arrival order
    always @(posedge i_clk)
    begin
        if (i_tx_valid && o_tx_ready)
            got.push_back(i_tx_data);
        #1 o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    end

    // Send bytes MSB-first, one per cycle; idle data is the inverse of the last
    task automatic push(input logic [7:0] q[$]);
        foreach (q[k])
        begin
            o_rx_valid = 1'b1;
            o_rx_data = q[k];
            @(posedge i_clk) #1;
        end
        o_rx_valid = 1'b0;
        o_rx_data = ~o_rx_data;
    endtask
endmodule

// [registration_packet_tail_fields_test.sv]
/*
 * Self-checking bench for the registration packet tail block.
 * Assumes rpt_pkg, rpt_tail, the peer model and the checker are compiled first.
 */
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch %0t got %0h want %0h", $time, (a), (b)); end end

// ==================================================================
// Bench top
module registration_packet_tail_fields_test;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_tx_start = 1'b0, i_tx_secure = 1'b0;
    logic i_aggr_capable = 1'b0, i_rx_start = 1'b0, i_rx_secure = 1'b0, i_rx_aggr = 1'b0;
    rpt_pkg::rpt_msg_e i_tx_msg = rpt_pkg::RPT_MSG_REQ, i_rx_msg = rpt_pkg::RPT_MSG_REQ;
    logic [47:0] hw = 48'ha1b2c3d4e5f6;
    logic [31:0] nonce = 32'h1234abcd;
    logic [7:0] sw = 8'h00, tx_data, rx_data;
    logic [13:0] lnid = 14'h0000, eid = 14'h3fff;
    logic [1:0] efm = 2'h0;
    logic [2:0] eseg = 3'h0;
    logic tx_ready, tx_valid, rx_valid;
    logic [7:0] segt[8] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80, 8'hc0, 8'hff};
    int num_errors = 0, checks_done = 0, cycles = 0;

    always #2 i_clk = ~i_clk;

    rpt_tail u_dut (.i_clk, .i_rst_n, .i_tx_start, .i_tx_msg, .i_tx_secure,
        .i_node_hw_identifier(hw), .i_tx_nonce(nonce), .i_aggr_capable, .o_tx_busy(),
        .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(), .i_tx_ready(tx_ready),
        .o_tx_aggregation_capable_flag(), .o_tx_local_node_id(), .i_rx_start, .i_rx_msg,
        .i_rx_secure, .i_rx_switch_identifier(sw), .i_rx_local_node_id(lnid),
        .i_rx_aggregation_capable_flag(i_rx_aggr), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
        .o_rx_done(), .o_rx_field_err(), .o_rx_hw_identifier(), .o_reg_nonce_counter(),
        .o_wrapped_subnet_key(), .o_wrapped_auth_key(), .o_keys_valid(),
        .o_assigned_local_node_id(), .o_switch_identifier(), .o_registered(),
        .o_aggr_enabled(), .o_mod_auto(), .o_sel_dbpsk_coded(), .o_sel_dqpsk_robust(),
        .o_sel_dbpsk_robust(), .o_seg_limit_en(), .o_seg_limit_bytes());

    rpt_peer u_peer (.i_clk, .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data));

    task automatic tally_and_finish();
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // Send one tail, hold start one extra cycle to see it refused, check the bytes
    task automatic tx_case(input rpt_pkg::rpt_msg_e msg, input logic sec);
        logic nc;
        int n;
        nc = sec && msg inside {rpt_pkg::RPT_MSG_REQ, rpt_pkg::RPT_MSG_RSP, rpt_pkg::RPT_MSG_REJ};
        u_peer.got.delete();
        nonce = nonce + 32'h01010101;
        i_tx_msg = msg;
        i_tx_secure = sec;
        i_aggr_capable = ~i_aggr_capable;
        i_tx_start = 1'b1;
        @(posedge i_clk) #1;
        @(posedge i_clk) #1;
        i_tx_start = 1'b0;
        `CHK(u_dut.o_tx_aggregation_capable_flag, i_aggr_capable)
        `CHK(u_dut.o_tx_local_node_id, msg == rpt_pkg::RPT_MSG_REQ ? 14'h3fff : eid)
        for (n = 0; n < 200 && tx_valid; n++)
            @(posedge i_clk) #1;
        `CHK(u_peer.got.size(), nc ? 11 : 7)
        for (n = 0; n < 6; n++)
            `CHK(u_peer.got[n], hw[47 - 8 * n -: 8])
        `CHK(u_peer.got[6], 8'h00)
        for (n = 0; nc && n < 4; n++)
            `CHK(u_peer.got[7 + n], nonce[31 - 8 * n -: 8])
    endtask

    // Peer sends one tail; expectations follow the field rules
    task automatic rx_case(input rpt_pkg::rpt_msg_e msg, input logic sec, input logic [7:0] ctrl);
        logic [7:0] b[$];
        logic [191:0] sk, ak;
        logic nc, ky, err;
        int k;
        nc = sec && msg inside {rpt_pkg::RPT_MSG_REQ, rpt_pkg::RPT_MSG_RSP, rpt_pkg::RPT_MSG_REJ};
        ky = sec && msg == rpt_pkg::RPT_MSG_RSP;
        err = ctrl[2:0] != 3'h0 || (msg != rpt_pkg::RPT_MSG_RSP && ctrl[7:3] != 5'h00);
        hw = {hw[46:0], hw[47]};
        for (k = 0; k < 6; k++)
            b.push_back(hw[47 - 8 * k -: 8]);
        b.push_back(ctrl);
        for (k = 0; nc && k < 4; k++)
            b.push_back(nonce[31 - 8 * k -: 8]);
        for (k = 0; ky && k < 48; k++)
            b.push_back(8'(k * 5 + 1));
        for (k = 0; k < 24; k++)
        begin
            sk[191 - 8 * k -: 8] = 8'(k * 5 + 1);
            ak[191 - 8 * k -: 8] = 8'(k * 5 + 121);
        end
        i_rx_msg = msg;
        i_rx_secure = sec;
        sw = sw + 8'h11;
        lnid = lnid + 14'h0123;
        i_rx_aggr = ~i_rx_aggr;
        i_rx_start = 1'b1;
        @(posedge i_clk) #1;
        i_rx_start = 1'b0;
        u_peer.push(b);
        for (k = 0; k < 5 && u_dut.o_rx_done !== 1'b1; k++)
            @(posedge i_clk) #1;
        `CHK(u_dut.o_rx_done, 1'b1)
        `CHK(u_dut.o_rx_field_err, err)
        `CHK(u_dut.o_rx_hw_identifier, hw)
        if (nc)
            `CHK(u_dut.o_reg_nonce_counter, nonce)
        if (ky)
        begin
            `CHK(u_dut.o_wrapped_subnet_key, sk)
            `CHK(u_dut.o_wrapped_auth_key, ak)
            `CHK(u_dut.o_keys_valid, 1'b1)
        end
        if (msg == rpt_pkg::RPT_MSG_RSP)
        begin
            eid = lnid;
            `CHK(u_dut.o_switch_identifier, sw)
            `CHK(u_dut.o_aggr_enabled, i_rx_aggr)
            `CHK(u_dut.o_registered, 1'b1)
            if (!err)
            begin
                efm = ctrl[7:6];
                eseg = ctrl[5:3];
            end
        end
        `CHK(u_dut.o_assigned_local_node_id, eid)
        `CHK({u_dut.o_mod_auto, u_dut.o_sel_dbpsk_coded, u_dut.o_sel_dqpsk_robust,
            u_dut.o_sel_dbpsk_robust}, 4'(4'h8 >> efm))
        `CHK(u_dut.o_seg_limit_en, eseg != 3'h0)
        if (eseg != 3'h0)
            `CHK(u_dut.o_seg_limit_bytes, segt[eseg])
        @(posedge i_clk) #1;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        @(posedge i_clk) #1;
        `CHK(u_dut.o_mod_auto, 1'b1)
        `CHK(u_dut.o_tx_local_node_id, 14'h3fff)
        tx_case(rpt_pkg::RPT_MSG_REQ, 1'b1);
        u_peer.slow = 1'b1;
        tx_case(rpt_pkg::RPT_MSG_REQ, 1'b0);
        for (int i = 0; i < 8; i++)
            rx_case(rpt_pkg::RPT_MSG_RSP, 1'b0, {2'(i), 3'(i), 3'h0});
        rx_case(rpt_pkg::RPT_MSG_RSP, 1'b1, 8'h70);
        rx_case(rpt_pkg::RPT_MSG_ACK, 1'b0, 8'hc8);
        rx_case(rpt_pkg::RPT_MSG_REJ, 1'b1, 8'h01);
        rx_case(rpt_pkg::RPT_MSG_RSP, 1'b0, 8'h4d);
        tx_case(rpt_pkg::RPT_MSG_ACK, 1'b1);
        u_peer.slow = 1'b0;
        tx_case(rpt_pkg::RPT_MSG_REJ, 1'b1);
        tx_case(rpt_pkg::RPT_MSG_UNR_S, 1'b1);
        tally_and_finish();
    end
endmodule

bind rpt_tail rpt_tail_props u_props (.i_clk, .i_rst_n, .i_tx_start, .i_tx_msg, .i_aggr_capable,
    .i_tx_ready, .o_tx_busy, .o_tx_valid, .o_tx_data, .o_tx_last, .o_tx_aggregation_capable_flag,
    .o_tx_local_node_id, .o_rx_done, .o_keys_valid, .o_mod_auto, .o_sel_dbpsk_coded,
    .o_sel_dqpsk_robust, .o_sel_dbpsk_robust, .o_seg_limit_en, .o_seg_limit_bytes);
